/* File: motor_cfg_defines.svh */
`ifndef MOTOR_CFG_DEFINES_SVH
`define MOTOR_CFG_DEFINES_SVH

// serial target address, value arbitrary
`define TARGET_ADDR        7'h52
`define BYTE_BITS          4'h8

// register addresses and reset values
`define PROT_ADDR          8'h94
`define DRIVE_ADDR         8'h95
`define PROT_RESET         16'h0000
`define DRIVE_RESET        16'h0000
`define UNMAPPED_READ      16'h0000

// protection_limit_config fields
`define OT_CLAMP_HI        15
`define OT_CLAMP_LO        14
`define CL_STUCK_BIT       13
`define OL_STUCK_BIT       12
`define NO_MOTOR_BIT       11
`define TORQUE_FAULT_BIT   10
`define SPEED_FAULT_BIT    9
`define LIMIT_HIT_BIT      8
`define ACCEL_HI           7
`define ACCEL_LO           4
`define LOCK_HI            3
`define LOCK_LO            1
`define RANGE_BIT          0

// drive_behaviour_config fields
`define SPD_KIND_BIT       15
`define FREQ_BIT           14
`define KT_HI              13
`define KT_LO              12
`define IND_SURGE_BIT      11
`define MECH_SURGE_BIT     10
`define MECH_MODE_BIT      9
`define IND_REL_BIT        8
`define CL_INHIBIT_BIT     7
`define RAMP_HI            6
`define RAMP_LO            4
`define DUTY_HI            3
`define DUTY_LO            2
`define EDGE_HI            1
`define EDGE_LO            0

// currents in 0.1 A units
`define CLAMP_NONE         6'h00
`define CLAMP_1A0          6'h0A
`define CLAMP_1A6          6'h10
`define CLAMP_2A0          6'h14
`define ACCEL_STEP_SHIFT   1
`define LOCK_R0_C0         6'h19
`define LOCK_R0_C1         6'h13
`define LOCK_R0_C2         6'h0F
`define LOCK_R0_C3         6'h09
`define LOCK_STEP_SHIFT    2

// switching frequency in kHz
`define FREQ_LOW_KHZ       6'h19
`define FREQ_HIGH_KHZ      6'h32

`endif

/* File: motor_cfg_pkg.sv */
package motor_cfg_pkg;

  typedef logic [5:0] tenth_amp_t;
  typedef logic [5:0] khz_t;

  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_ADDR_ACK,
    LINK_WDATA,
    LINK_WACK,
    LINK_RDATA,
    LINK_RACK
  } link_state_e;

endpackage : motor_cfg_pkg

/* File: serial_target_link.sv */
`timescale 1ns/1ps
`include "motor_cfg_defines.svh"

module serial_target_link (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [7:0] i_tx_data,
  output logic            o_sda_oe_n,
  output logic            o_start,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_tx_req
);
  import motor_cfg_pkg::*;

  logic        scl_m, scl_s, scl_d;
  logic        sda_m, sda_s, sda_d;
  logic [7:0]  shreg;
  logic [3:0]  bitcnt;
  logic        rw;
  link_state_e st;
  logic        scl_rise, scl_fall, start_cond, stop_cond;

  // pin synchronisers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {i_sda, sda_m, sda_s};
    end
  end

  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  assign o_rx_data  = shreg;

  // byte framing
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st         <= LINK_IDLE;
      o_sda_oe_n <= 1'b1;
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      rw         <= 1'b0;
      o_rx_valid <= 1'b0;
      o_tx_req   <= 1'b0;
      o_start    <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      o_tx_req   <= 1'b0;
      o_start    <= start_cond;
      if (start_cond) begin
        st         <= LINK_ADDR;
        bitcnt     <= 4'h0;
        o_sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        st         <= LINK_IDLE;
        o_sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (st == LINK_ADDR || st == LINK_WDATA) begin
          shreg  <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end else if (st == LINK_RACK) begin
          if (sda_s) begin
            st <= LINK_IDLE;
          end else begin
            o_tx_req <= 1'b1;
          end
        end
      end else if (scl_fall) begin
        unique case (st)
          LINK_IDLE: begin
          end
          LINK_ADDR: begin
            if (bitcnt == `BYTE_BITS) begin
              if (shreg[7:1] == `TARGET_ADDR) begin
                o_sda_oe_n <= 1'b0;
                rw         <= shreg[0];
                o_tx_req   <= shreg[0];
                st         <= LINK_ADDR_ACK;
              end else begin
                st <= LINK_IDLE;
              end
            end
          end
          LINK_ADDR_ACK: begin
            if (rw) begin
              o_sda_oe_n <= i_tx_data[7];
              shreg      <= {i_tx_data[6:0], 1'b0};
              bitcnt     <= 4'h1;
              st         <= LINK_RDATA;
            end else begin
              o_sda_oe_n <= 1'b1;
              bitcnt     <= 4'h0;
              st         <= LINK_WDATA;
            end
          end
          LINK_WDATA: begin
            if (bitcnt == `BYTE_BITS) begin
              o_sda_oe_n <= 1'b0;
              o_rx_valid <= 1'b1;
              st         <= LINK_WACK;
            end
          end
          LINK_WACK: begin
            o_sda_oe_n <= 1'b1;
            bitcnt     <= 4'h0;
            st         <= LINK_WDATA;
          end
          LINK_RDATA: begin
            if (bitcnt == `BYTE_BITS) begin
              o_sda_oe_n <= 1'b1;
              st         <= LINK_RACK;
            end else begin
              o_sda_oe_n <= shreg[7];
              shreg      <= {shreg[6:0], 1'b0};
              bitcnt     <= bitcnt + 4'h1;
            end
          end
          LINK_RACK: begin
            o_sda_oe_n <= i_tx_data[7];
            shreg      <= {i_tx_data[6:0], 1'b0};
            bitcnt     <= 4'h1;
            st         <= LINK_RDATA;
          end
        endcase
      end
    end
  end

endmodule : serial_target_link

/* File: protection_limit_config_regs.sv */
`timescale 1ns/1ps
`include "motor_cfg_defines.svh"
// Contract
// - overtemp clamp: none, 1 A, 1.6 A, 2 A
// - bit 13 enables closed-loop stuck detector
// - bit 12 enables open-loop stuck detector
// - bit 11 enables no-motor detector
// - bit 10 enables torque-constant fault detector
// - bit 9 enables speed fault detector
// - bit 8 enables limit-hit lock detection
// - accel limit off at zero, else n*0.2 A
// - range 0: low two bits pick 2.5..0.9 A
// - range 1: codes give 0.4..3.2 A steps
// - bit 0 selects lock limit range
// - protection register at 0x94, reset zero, RW
// - drive register at 0x95, reset zero, fields
// - speed input kind: analog or PWM
// - switching frequency 25 kHz or 50 kHz

module protection_limit_config_regs (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  output logic                   o_sda_oe_n,
  output motor_cfg_pkg::tenth_amp_t o_overtemp_current_clamp,
  output motor_cfg_pkg::tenth_amp_t o_accel_current_threshold,
  output motor_cfg_pkg::tenth_amp_t o_lock_current_limit,
  output logic                   o_closed_loop_stuck_detect_en,
  output logic                   o_open_loop_stuck_detect_en,
  output logic                   o_no_motor_detect_en,
  output logic                   o_torque_const_fault_en,
  output logic                   o_speed_fault_detect_en,
  output logic                   o_limit_hit_lock_detect_en,
  output logic                   o_lock_limit_range_sel,
  output logic                   o_speed_input_kind,
  output logic                   o_switching_freq_sel,
  output motor_cfg_pkg::khz_t    o_switching_freq_khz,
  output logic [1:0]             o_torque_const_lock_window,
  output logic                   o_inductive_surge_guard_en,
  output logic                   o_mechanical_surge_guard_en,
  output logic                   o_mechanical_surge_guard_mode,
  output logic                   o_inductive_release_mode,
  output logic                   o_closed_loop_inhibit,
  output logic [2:0]             o_closed_loop_ramp_rate,
  output logic [1:0]             o_minimum_duty_floor,
  output logic [1:0]             o_phase_edge_rate
);
  import motor_cfg_pkg::*;

  logic [15:0] protection_limit_config;
  logic [15:0] drive_behaviour_config;
  logic [7:0]  ptr;
  logic [1:0]  byte_idx;
  logic [7:0]  msb_hold;
  logic [7:0]  tx_byte;
  logic        rd_hi;
  logic        link_start;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_req;
  logic        wr_commit;
  logic [15:0] wr_word;
  logic [15:0] rd_word;

  function automatic logic [15:0] read_word(input logic [7:0]  addr,
                                            input logic [15:0] prot,
                                            input logic [15:0] drive);
    if (addr == `PROT_ADDR) begin
      return prot;
    end else if (addr == `DRIVE_ADDR) begin
      return drive;
    end
    return `UNMAPPED_READ;
  endfunction : read_word

  function automatic tenth_amp_t clamp_of(input logic [1:0] code);
    unique case (code)
      2'h0: return `CLAMP_NONE;
      2'h1: return `CLAMP_1A0;
      2'h2: return `CLAMP_1A6;
      2'h3: return `CLAMP_2A0;
    endcase
  endfunction : clamp_of

  function automatic tenth_amp_t lock_of(input logic [2:0] code, input logic range_sel);
    if (range_sel) begin
      return tenth_amp_t'(({3'h0, code} + 6'h01) << `LOCK_STEP_SHIFT);
    end
    unique case (code[1:0])
      2'h0: return `LOCK_R0_C0;
      2'h1: return `LOCK_R0_C1;
      2'h2: return `LOCK_R0_C2;
      2'h3: return `LOCK_R0_C3;
    endcase
  endfunction : lock_of

  serial_target_link u_link (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .i_tx_data  (tx_byte),
    .o_sda_oe_n (o_sda_oe_n),
    .o_start    (link_start),
    .o_rx_valid (rx_valid),
    .o_rx_data  (rx_data),
    .o_tx_req   (tx_req)
  );

  assign wr_commit = rx_valid && (byte_idx == 2'h2);
  assign wr_word   = {msb_hold, rx_data};
  assign rd_word   = read_word(ptr, protection_limit_config, drive_behaviour_config);

  // pointer, byte pairing and read data
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ptr      <= 8'h00;
      byte_idx <= 2'h0;
      msb_hold <= 8'h00;
      tx_byte  <= 8'h00;
      rd_hi    <= 1'b1;
    end else if (link_start) begin
      byte_idx <= 2'h0;
      rd_hi    <= 1'b1;
    end else if (rx_valid) begin
      if (byte_idx == 2'h0) begin
        ptr      <= rx_data;
        byte_idx <= 2'h1;
      end else if (byte_idx == 2'h1) begin
        msb_hold <= rx_data;
        byte_idx <= 2'h2;
      end else begin
        ptr      <= ptr + 8'h01;
        byte_idx <= 2'h1;
      end
    end else if (tx_req) begin
      if (rd_hi) begin
        tx_byte <= rd_word[15:8];
        rd_hi   <= 1'b0;
      end else begin
        tx_byte <= rd_word[7:0];
        rd_hi   <= 1'b1;
        ptr     <= ptr + 8'h01;
      end
    end
  end

  // register storage, every bit kept as written
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      protection_limit_config <= `PROT_RESET;
      drive_behaviour_config  <= `DRIVE_RESET;
    end else if (wr_commit) begin
      if (ptr == `PROT_ADDR) begin
        protection_limit_config <= wr_word;
      end
      if (ptr == `DRIVE_ADDR) begin
        drive_behaviour_config <= wr_word;
      end
    end
  end

  // decoded current limits and switching frequency
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_overtemp_current_clamp  <= clamp_of(2'(`PROT_RESET >> `OT_CLAMP_LO));
      o_accel_current_threshold <= `CLAMP_NONE;
      o_lock_current_limit      <= lock_of(3'h0, 1'b0);
      o_switching_freq_khz      <= `FREQ_LOW_KHZ;
    end else begin
      o_overtemp_current_clamp  <=
        clamp_of(protection_limit_config[`OT_CLAMP_HI:`OT_CLAMP_LO]);
      o_accel_current_threshold <= tenth_amp_t'(
        {2'h0, protection_limit_config[`ACCEL_HI:`ACCEL_LO]} << `ACCEL_STEP_SHIFT);
      o_lock_current_limit      <= lock_of(protection_limit_config[`LOCK_HI:`LOCK_LO],
        protection_limit_config[`RANGE_BIT]);
      o_switching_freq_khz      <= drive_behaviour_config[`FREQ_BIT] ?
        `FREQ_HIGH_KHZ : `FREQ_LOW_KHZ;
    end
  end

  assign o_closed_loop_stuck_detect_en = protection_limit_config[`CL_STUCK_BIT];
  assign o_open_loop_stuck_detect_en   = protection_limit_config[`OL_STUCK_BIT];
  assign o_no_motor_detect_en          = protection_limit_config[`NO_MOTOR_BIT];
  assign o_torque_const_fault_en       = protection_limit_config[`TORQUE_FAULT_BIT];
  assign o_speed_fault_detect_en       = protection_limit_config[`SPEED_FAULT_BIT];
  assign o_limit_hit_lock_detect_en    = protection_limit_config[`LIMIT_HIT_BIT];
  assign o_lock_limit_range_sel        = protection_limit_config[`RANGE_BIT];
  assign o_speed_input_kind            = drive_behaviour_config[`SPD_KIND_BIT];
  assign o_switching_freq_sel          = drive_behaviour_config[`FREQ_BIT];
  assign o_torque_const_lock_window    = drive_behaviour_config[`KT_HI:`KT_LO];
  assign o_inductive_surge_guard_en    = drive_behaviour_config[`IND_SURGE_BIT];
  assign o_mechanical_surge_guard_en   = drive_behaviour_config[`MECH_SURGE_BIT];
  assign o_mechanical_surge_guard_mode = drive_behaviour_config[`MECH_MODE_BIT];
  assign o_inductive_release_mode      = drive_behaviour_config[`IND_REL_BIT];
  assign o_closed_loop_inhibit         = drive_behaviour_config[`CL_INHIBIT_BIT];
  assign o_closed_loop_ramp_rate       = drive_behaviour_config[`RAMP_HI:`RAMP_LO];
  assign o_minimum_duty_floor          = drive_behaviour_config[`DUTY_HI:`DUTY_LO];
  assign o_phase_edge_rate             = drive_behaviour_config[`EDGE_HI:`EDGE_LO];

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_clamp_codes: assert property (
    (protection_limit_config[15:14] == 2'h2 |=> o_overtemp_current_clamp == 6'h10)
    and (protection_limit_config[15:14] == 2'h0 |=> o_overtemp_current_clamp == 6'h00))
    else $error("overtemp clamp decode wrong");

  a_detect_enables: assert property (
    wr_commit && ptr == 8'h94 |=> {o_closed_loop_stuck_detect_en,
      o_open_loop_stuck_detect_en, o_no_motor_detect_en, o_torque_const_fault_en,
      o_speed_fault_detect_en, o_limit_hit_lock_detect_en} == $past(wr_word[13:8]))
    else $error("detector enables not taken from write");

  a_accel_step: assert property (
    protection_limit_config[7:4] == 4'h5 |=> o_accel_current_threshold == 6'h0A)
    else $error("accel threshold not n times 0.2 A");

  a_lock_range0: assert property (
    !protection_limit_config[0] && protection_limit_config[2:1] == 2'h1
    |=> o_lock_current_limit == 6'h13)
    else $error("range 0 lock limit wrong");

  a_lock_range1: assert property (
    protection_limit_config[0] && protection_limit_config[3:1] == 3'h7
    |=> o_lock_current_limit == 6'h20)
    else $error("range 1 lock limit wrong");

  a_prot_reset: assert property (
    $past(i_rst) |-> protection_limit_config == 16'h0000 && drive_behaviour_config == 16'h0000)
    else $error("registers not zero after reset");

  a_drive_write: assert property (
    wr_commit && ptr == 8'h95 |=> drive_behaviour_config == $past(wr_word)
    && o_speed_input_kind == $past(wr_word[15]) && ptr == $past(ptr) + 8'h01)
    else $error("drive register write lost");

  a_freq_khz: assert property (
    o_switching_freq_khz == ($past(o_switching_freq_sel) ? 6'h32 : 6'h19))
    else $error("switching frequency does not follow its select bit");

  a_top_bit_kept: assert property (
    wr_commit && ptr == 8'h94 && wr_word[3:0] == 4'hA
    |=> protection_limit_config[3] ##1 o_lock_current_limit == 6'h13)
    else $error("lock limit top bit not stored");

  c_prot_write: cover property (wr_commit && ptr == 8'h94);
  c_drive_write: cover property (wr_commit && ptr == 8'h95);
  c_read_pair: cover property (tx_req && rd_hi ##[1:1000] tx_req && !rd_hi);
  c_range1: cover property ($rose(o_lock_limit_range_sel));

endmodule : protection_limit_config_regs

/* File: serial_host_model.sv */
`timescale 1ns/1ps

module serial_host_model (
  input  wire logic i_clock,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // open drain: o_sda high means released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask : idle

  task automatic start_cond();
    o_sda <= 1'b1;
    idle(8);
    o_scl <= 1'b1;
    idle(16);
    o_sda <= 1'b0;
    idle(16);
    o_scl <= 1'b0;
    idle(8);
  endtask : start_cond

  task automatic stop_cond();
    o_sda <= 1'b0;
    idle(8);
    o_scl <= 1'b1;
    idle(16);
    o_sda <= 1'b1;
    idle(16);
  endtask : stop_cond

  // data set in low phase, sampled at end of high phase
  task automatic bit_xfer(input logic tx, output logic rx);
    o_sda <= tx;
    idle(8);
    o_scl <= 1'b1;
    idle(16);
    rx = i_sda;
    o_scl <= 1'b0;
    idle(8);
  endtask : bit_xfer

  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                           output logic ack_out);
    logic b;
    for (int k = 7; k >= 0; k--) begin
      bit_xfer(tx[k], b);
      rx[k] = b;
    end
    bit_xfer(ack_in, ack_out);
  endtask : xfer_byte
endmodule : serial_host_model

/* File: testbench.sv */
`timescale 1ns/1ps
`include "motor_cfg_defines.svh"
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

module testbench;
  import motor_cfg_pkg::*;
  localparam logic [7:0] WR_BYTE = {`TARGET_ADDR, 1'b0};
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic        scl;
  logic        host_sda;
  logic        sda_oe_n;
  wire         sda_wire = host_sda & sda_oe_n;
  tenth_amp_t  clamp;
  tenth_amp_t  accel;
  tenth_amp_t  lock;
  khz_t        khz;
  logic [5:0]  en;
  logic        range_sel;
  logic [15:0] drv;
  int          err_count   = 0;
  int          checks_done = 0;

  always #4 i_clock = ~i_clock;

  protection_limit_config_regs u_protection_limit_config_regs (
    .i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_wire), .o_sda_oe_n(sda_oe_n),
    .o_overtemp_current_clamp(clamp), .o_accel_current_threshold(accel),
    .o_lock_current_limit(lock), .o_closed_loop_stuck_detect_en(en[5]),
    .o_open_loop_stuck_detect_en(en[4]), .o_no_motor_detect_en(en[3]),
    .o_torque_const_fault_en(en[2]), .o_speed_fault_detect_en(en[1]),
    .o_limit_hit_lock_detect_en(en[0]), .o_lock_limit_range_sel(range_sel),
    .o_speed_input_kind(drv[15]), .o_switching_freq_sel(drv[14]), .o_switching_freq_khz(khz),
    .o_torque_const_lock_window(drv[13:12]), .o_inductive_surge_guard_en(drv[11]),
    .o_mechanical_surge_guard_en(drv[10]), .o_mechanical_surge_guard_mode(drv[9]),
    .o_inductive_release_mode(drv[8]), .o_closed_loop_inhibit(drv[7]),
    .o_closed_loop_ramp_rate(drv[6:4]), .o_minimum_duty_floor(drv[3:2]),
    .o_phase_edge_rate(drv[1:0]));

  serial_host_model u_serial_host_model (
    .i_clock(i_clock), .i_sda(sda_wire), .o_scl(scl), .o_sda(host_sda));

  function automatic logic [5:0] clamp_exp(input logic [1:0] c);
    case (c)
      2'h0: return 6'h00;
      2'h1: return 6'h0A;
      2'h2: return 6'h10;
      default: return 6'h14;
    endcase
  endfunction : clamp_exp

  function automatic logic [5:0] lock_exp(input logic [2:0] c, input logic r);
    if (r) return {1'b0, c, 2'h0} + 6'h04;
    case (c[1:0])
      2'h0: return 6'h19;
      2'h1: return 6'h13;
      2'h2: return 6'h0F;
      default: return 6'h09;
    endcase
  endfunction : lock_exp

  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic send_frame(input logic [7:0] q[$], output logic addr_ack);
    logic [7:0] rx;
    logic       a;
    u_serial_host_model.start_cond();
    foreach (q[k]) begin
      u_serial_host_model.xfer_byte(q[k], 1'b1, rx, a);
      if (k == 0) addr_ack = a;
      else if (addr_ack === 1'b0) `CHECK(a, 1'b0)
    end
    u_serial_host_model.stop_cond();
  endtask : send_frame

  task automatic reg_write(input logic [7:0] addr, input logic [15:0] val);
    logic a;
    send_frame('{WR_BYTE, addr, val[15:8], val[7:0]}, a);
    `CHECK(a, 1'b0)
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr, output logic [15:0] val);
    logic [7:0] rx;
    logic       a;
    u_serial_host_model.start_cond();
    u_serial_host_model.xfer_byte(WR_BYTE, 1'b1, rx, a);
    u_serial_host_model.xfer_byte(addr, 1'b1, rx, a);
    u_serial_host_model.start_cond();
    u_serial_host_model.xfer_byte({`TARGET_ADDR, 1'b1}, 1'b1, rx, a);
    `CHECK(a, 1'b0)
    u_serial_host_model.xfer_byte(8'hFF, 1'b0, val[15:8], a);
    u_serial_host_model.xfer_byte(8'hFF, 1'b1, val[7:0], a);
    u_serial_host_model.stop_cond();
  endtask : reg_read

  task automatic check_prot(input logic [15:0] v);
    logic [15:0] rd;
    `CHECK(clamp, clamp_exp(v[15:14]))
    `CHECK(en[5], v[13])
    `CHECK(en[4], v[12])
    `CHECK(en[3], v[11])
    `CHECK(en[2], v[10])
    `CHECK(en[1], v[9])
    `CHECK(en[0], v[8])
    `CHECK(accel, {1'b0, v[7:4], 1'b0})
    `CHECK(lock, lock_exp(v[3:1], v[0]))
    `CHECK(range_sel, v[0])
    reg_read(`PROT_ADDR, rd);
    `CHECK(rd, v)
  endtask : check_prot

  task automatic reset_defaults();
    logic [15:0] rd;
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    `CHECK(drv, 16'h0000)
    `CHECK(khz, 6'h19)
    check_prot(16'h0000);
    reg_read(`DRIVE_ADDR, rd);
    `CHECK(rd, 16'h0000)
  endtask : reset_defaults

  task automatic prot_table();
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {i[1:0], 6'(i * 11), 4'(15 - i), i[2:0], i[3]};
      reg_write(`PROT_ADDR, v);
      check_prot(v);
    end
  endtask : prot_table

  task automatic drive_patterns();
    logic [15:0] pats[2] = '{16'hA5C3, 16'h5A3C};
    logic [15:0] rd;
    foreach (pats[k]) begin
      reg_write(`DRIVE_ADDR, pats[k]);
      `CHECK(drv, pats[k])
      `CHECK(drv[15], pats[k][15])
      `CHECK(khz, pats[k][14] ? 6'h32 : 6'h19)
      reg_read(`DRIVE_ADDR, rd);
      `CHECK(rd, pats[k])
    end
  endtask : drive_patterns

  task automatic refusals();
    logic [15:0] rd;
    logic        a;
    reg_write(`PROT_ADDR, 16'h1234);
    send_frame('{8'h54, `PROT_ADDR, 8'hFF, 8'hFF}, a);
    `CHECK(a, 1'b1)
    send_frame('{WR_BYTE, `PROT_ADDR, 8'hFF}, a);
    reg_write(8'h96, 16'hFFFF);
    reg_read(8'h96, rd);
    `CHECK(rd, 16'h0000)
    check_prot(16'h1234);
    send_frame('{WR_BYTE, `PROT_ADDR, 8'h81, 8'h0F, 8'hC3, 8'h3C}, a);
    `CHECK(drv, 16'hC33C)
    check_prot(16'h810F);
  endtask : refusals

  initial begin
    reset_defaults();
    prot_table();
    drive_patterns();
    refusals();
    reset_defaults();
    complete_run();
  end

  // hang guard, about one and a half times the expected run
  initial begin
    repeat (100000) @(posedge i_clock);
    err_count++;
    complete_run();
  end
endmodule : testbench
